//--- clk_ctl_cfg.svh
/*
 * Constants for the clock driver control block: reset values, default
 * sizes and synchroniser depth. Assumes it is included by bare name.
 */
// Operation
// R01: Lock output is high while the PLL reports lock and low otherwise.
// R02: Gated disable applies when the style pin is high or the gated-disable bit is set.
// R03: In gated disable true outputs stop high when the level bit is 0, low when 1, complements opposite.
// R04: With style pin low and gated-disable bit clear, disabled outputs go high impedance.
// R05: Test reset low resets the test logic at once, with no test clock edge.
// R06: Select pin high hands the shared pins to the test port.
// R07: Select pin low hands the shared pins to the two-wire port and holds the TAP in reset.
// R08: Serial test output is high impedance unless data is being shifted out.
// R09: Serial test output changes on the falling test clock edge.
// R10: Mode select is sampled and the TAP moves on the rising test clock edge.
// R11: Serial test input is captured on the rising test clock edge.
// R12: In two-wire mode only, the two straps set part of the target address.
// R13: A bank is disabled synchronously when its enable pin is high or its bit is set.
// R14: The TAP is the standard sixteen-state machine, one state per rising edge.
`ifndef CLK_CTL_CFG_SVH
`define CLK_CTL_CFG_SVH

`define DEF_NUM_BANKS 5
`define DEF_DR_WIDTH 8
`define SYNC_STAGES 2
`define LOCK_RST 1'b0
`define OE_N_RST 1'b1
`define TDO_RST 1'b0
`define TARGET_ID_RST 2'h0
`define CFG_WORD_RST 8'h00

`endif

//--- clk_ctl_pkg.sv
/*
 * Types for the clock driver control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package clk_ctl_pkg;
	// Sixteen TAP controller states
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		DR_SELECT, DR_CAPTURE, DR_SHIFT, DR_EXIT1, DR_PAUSE, DR_EXIT2, DR_UPDATE,
		IR_SELECT, IR_CAPTURE, IR_SHIFT, IR_EXIT1, IR_PAUSE, IR_EXIT2, IR_UPDATE
	} tap_state_t;
endpackage : clk_ctl_pkg

//--- tap_link_if.sv
/*
 * Carrier between the test-clock TAP logic and the reference-clock core.
 * Assumes the producer of each signal is the modport that outputs it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_cfg.svh"
interface tap_link_if #(parameter int DR_WIDTH = `DEF_DR_WIDTH);
	clk_ctl_pkg::tap_state_t state;
	logic update_toggle;
	logic [DR_WIDTH-1:0] dr_word;
	logic tdo;
	logic tdo_oe_n;

	modport tap (output state, output update_toggle, output dr_word,
		output tdo, output tdo_oe_n);
	modport core (input state, input update_toggle, input dr_word,
		input tdo, input tdo_oe_n);
endinterface : tap_link_if
`default_nettype wire

//--- tap_ctrl.sv
/*
 * TAP controller and data shift register on the test clock.
 * Assumes trst_n comes straight from the select/reset pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_cfg.svh"
module tap_ctrl #(
	parameter int DR_WIDTH = `DEF_DR_WIDTH
) (
	input wire logic test_clock_in,
	input wire logic trst_n_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	tap_link_if.tap link
);
	clk_ctl_pkg::tap_state_t state_reg;
	clk_ctl_pkg::tap_state_t state_next;
	logic [DR_WIDTH-1:0] shift_reg;
	logic [DR_WIDTH-1:0] hold_reg;
	logic toggle_reg;
	logic tdo_reg;
	logic oe_n_reg;
	wire shifting = (state_reg == clk_ctl_pkg::DR_SHIFT) || (state_reg == clk_ctl_pkg::IR_SHIFT);

	// Standard next-state map
	always_comb
	begin
		unique case (state_reg)
			clk_ctl_pkg::TAP_RESET: state_next = tms_in ? clk_ctl_pkg::TAP_RESET : clk_ctl_pkg::TAP_IDLE; // R14
			clk_ctl_pkg::TAP_IDLE: state_next = tms_in ? clk_ctl_pkg::DR_SELECT : clk_ctl_pkg::TAP_IDLE;
			clk_ctl_pkg::DR_SELECT: state_next = tms_in ? clk_ctl_pkg::IR_SELECT : clk_ctl_pkg::DR_CAPTURE;
			clk_ctl_pkg::DR_CAPTURE: state_next = tms_in ? clk_ctl_pkg::DR_EXIT1 : clk_ctl_pkg::DR_SHIFT;
			clk_ctl_pkg::DR_SHIFT: state_next = tms_in ? clk_ctl_pkg::DR_EXIT1 : clk_ctl_pkg::DR_SHIFT;
			clk_ctl_pkg::DR_EXIT1: state_next = tms_in ? clk_ctl_pkg::DR_UPDATE : clk_ctl_pkg::DR_PAUSE;
			clk_ctl_pkg::DR_PAUSE: state_next = tms_in ? clk_ctl_pkg::DR_EXIT2 : clk_ctl_pkg::DR_PAUSE;
			clk_ctl_pkg::DR_EXIT2: state_next = tms_in ? clk_ctl_pkg::DR_UPDATE : clk_ctl_pkg::DR_SHIFT;
			clk_ctl_pkg::DR_UPDATE: state_next = tms_in ? clk_ctl_pkg::DR_SELECT : clk_ctl_pkg::TAP_IDLE;
			clk_ctl_pkg::IR_SELECT: state_next = tms_in ? clk_ctl_pkg::TAP_RESET : clk_ctl_pkg::IR_CAPTURE;
			clk_ctl_pkg::IR_CAPTURE: state_next = tms_in ? clk_ctl_pkg::IR_EXIT1 : clk_ctl_pkg::IR_SHIFT;
			clk_ctl_pkg::IR_SHIFT: state_next = tms_in ? clk_ctl_pkg::IR_EXIT1 : clk_ctl_pkg::IR_SHIFT;
			clk_ctl_pkg::IR_EXIT1: state_next = tms_in ? clk_ctl_pkg::IR_UPDATE : clk_ctl_pkg::IR_PAUSE;
			clk_ctl_pkg::IR_PAUSE: state_next = tms_in ? clk_ctl_pkg::IR_EXIT2 : clk_ctl_pkg::IR_PAUSE;
			clk_ctl_pkg::IR_EXIT2: state_next = tms_in ? clk_ctl_pkg::IR_UPDATE : clk_ctl_pkg::IR_SHIFT;
			clk_ctl_pkg::IR_UPDATE: state_next = tms_in ? clk_ctl_pkg::DR_SELECT : clk_ctl_pkg::TAP_IDLE;
		endcase
	end

	// State and capture on the rising edge; pin low resets at once
	always_ff @(posedge test_clock_in or negedge trst_n_in)
	begin
		if (!trst_n_in)
		begin
			state_reg <= clk_ctl_pkg::TAP_RESET; // R05 R07
			shift_reg <= `CFG_WORD_RST;
			hold_reg <= `CFG_WORD_RST;
			toggle_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next; // R10 R14
			if (state_reg == clk_ctl_pkg::DR_CAPTURE)
				shift_reg <= hold_reg; // Read back the last word loaded
			else if (state_reg == clk_ctl_pkg::DR_SHIFT)
				shift_reg <= {tdi_in, shift_reg[DR_WIDTH-1:1]}; // R11
			if (state_reg == clk_ctl_pkg::DR_UPDATE)
			begin
				hold_reg <= shift_reg;
				toggle_reg <= ~toggle_reg; // Event crosses as a toggle
			end
		end
	end

	// Output half a test clock later so the host samples a settled bit
	always_ff @(negedge test_clock_in or negedge trst_n_in)
	begin
		if (!trst_n_in)
		begin
			tdo_reg <= `TDO_RST;
			oe_n_reg <= `OE_N_RST;
		end
		else
		begin
			tdo_reg <= shift_reg[0]; // R09
			oe_n_reg <= ~shifting; // R08
		end
	end

	assign link.state = state_reg;
	assign link.update_toggle = toggle_reg;
	assign link.dr_word = hold_reg;
	assign link.tdo = tdo_reg;
	assign link.tdo_oe_n = oe_n_reg;
endmodule : tap_ctrl
`default_nettype wire

//--- clk_ctl_top.sv
/*
 * Control logic of a programmable clock driver: programming port select,
 * TAP pin behaviour, output disable style and lock indication.
 * Assumes the PLL and its bank clocks come from outside on ref_clk_in's
 * side, and the test clock is a separate, unrelated clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_cfg.svh"
module clk_ctl_top #(
	parameter int NUM_BANKS = `DEF_NUM_BANKS,
	parameter int DR_WIDTH = `DEF_DR_WIDTH
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Shared programming pins
	input wire logic test_clock_in,
	input wire logic trst_sel_n_in,
	input wire logic tms_strap_lo_in,
	input wire logic tdi_in,
	input wire logic tdo_strap_hi_in,
	output logic tdo_out,
	output logic tdo_oe_n_out,
	// PLL status and output control
	input wire logic pll_locked_in,
	input wire logic disable_style_pin_in,
	input wire logic cfg_gated_disable_in,
	input wire logic cfg_stop_level_in,
	input wire logic power_down_n_in,
	input wire logic [NUM_BANKS-1:0] bank_output_disable_n_in,
	input wire logic [NUM_BANKS-1:0] cfg_bank_disable_in,
	input wire logic [NUM_BANKS-1:0] bank_src_in,
	input wire logic feedback_src_in,
	// Clock outputs with enables, low while driving
	output logic [NUM_BANKS-1:0] bank_clk_out,
	output logic [NUM_BANKS-1:0] bank_clk_n_out,
	output logic [NUM_BANKS-1:0] bank_oe_n_out,
	output logic feedback_clk_out,
	output logic feedback_clk_n_out,
	output logic feedback_oe_n_out,
	// Status toward the rest of the chip
	output logic lock_out,
	output logic jtag_mode_out,
	output logic i2c_mode_out,
	output logic [1:0] target_id_out,
	output logic [3:0] tap_state_out,
	output logic [DR_WIDTH-1:0] cfg_word_out,
	output logic cfg_word_valid_out
);
	tap_link_if #(.DR_WIDTH(DR_WIDTH)) link ();

	// Test logic on its own clock, reset straight from the pin
	tap_ctrl #(
		.DR_WIDTH(DR_WIDTH)
	) u_tap (
		.test_clock_in(test_clock_in),
		.trst_n_in(trst_sel_n_in), // R05 R07
		.tms_in(tms_strap_lo_in),
		.tdi_in(tdi_in),
		.link(link)
	);

	// Pin side of the serial output: only driven in test-port mode
	assign tdo_out = link.tdo;
	assign tdo_oe_n_out = link.tdo_oe_n | ~trst_sel_n_in; // R06 R08

	// Two-stage synchronisers for every asynchronous level
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] async_lvl;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	assign async_lvl = {link.update_toggle, pll_locked_in, trst_sel_n_in,
		tms_strap_lo_in, tdo_strap_hi_in, disable_style_pin_in,
		power_down_n_in, cfg_gated_disable_in, cfg_stop_level_in};

	// First stage feeds only the second
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= async_lvl;
			sync2_reg <= sync1_reg;
		end
	end

	wire s_cfg_stop_level = sync2_reg[0];
	wire s_cfg_gated = sync2_reg[1];
	wire s_power_down_n = sync2_reg[2];
	wire s_style_pin = sync2_reg[3];
	wire s_strap_hi = sync2_reg[4];
	wire s_strap_lo = sync2_reg[5];
	wire s_sel = sync2_reg[6];
	wire s_locked = sync2_reg[7];
	wire s_toggle = sync2_reg[8];

	// Per-bank disable requests pass the same two stages
	logic [NUM_BANKS-1:0] bank_sync1_reg;
	logic [NUM_BANKS-1:0] bank_sync2_reg;
	logic [NUM_BANKS-1:0] bit_sync1_reg;
	logic [NUM_BANKS-1:0] bit_sync2_reg;

	// Reset releases to disabled so outputs start quiet
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			bank_sync1_reg <= '1;
			bank_sync2_reg <= '1;
			bit_sync1_reg <= '0;
			bit_sync2_reg <= '0;
		end
		else
		begin
			bank_sync1_reg <= bank_output_disable_n_in;
			bank_sync2_reg <= bank_sync1_reg;
			bit_sync1_reg <= cfg_bank_disable_in;
			bit_sync2_reg <= bit_sync1_reg;
		end
	end

	// Lock indication and port mode
	logic lock_reg;
	logic jtag_mode_reg;
	logic [1:0] target_id_reg;
	logic [1:0] target_id_next;
	wire i2c_mode = ~s_sel; // R07
	assign target_id_next = i2c_mode ? {s_strap_hi, s_strap_lo} : target_id_reg; // R12

	// Straps only count in two-wire mode; in test mode the pins carry
	// test traffic, so the last strap value is held instead
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			lock_reg <= `LOCK_RST;
			jtag_mode_reg <= 1'b0;
			target_id_reg <= `TARGET_ID_RST;
		end
		else
		begin
			lock_reg <= s_locked; // R01
			jtag_mode_reg <= s_sel; // R06
			target_id_reg <= target_id_next; // R12
		end
	end

	assign lock_out = lock_reg;
	assign jtag_mode_out = jtag_mode_reg;
	assign i2c_mode_out = ~jtag_mode_reg;
	assign target_id_out = target_id_reg;

	// Loaded words from the test port cross by toggle; the word itself is
	// stable in its holding register long before the toggle arrives
	logic toggle_seen_reg;
	logic [DR_WIDTH-1:0] cfg_word_reg;
	logic cfg_valid_reg;
	wire word_event = s_toggle ^ toggle_seen_reg;

	// Capture on the event, pulse valid for one cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			toggle_seen_reg <= 1'b0;
			cfg_word_reg <= `CFG_WORD_RST;
			cfg_valid_reg <= 1'b0;
		end
		else
		begin
			toggle_seen_reg <= s_toggle;
			cfg_valid_reg <= word_event;
			if (word_event)
				cfg_word_reg <= link.dr_word;
		end
	end

	assign cfg_word_out = cfg_word_reg;
	assign cfg_word_valid_out = cfg_valid_reg;

	// TAP state is a multi-bit value; it is sampled twice and accepted
	// only when two samples agree, so a torn code never reaches the port
	logic [3:0] tap_s1_reg;
	logic [3:0] tap_s2_reg;
	logic [3:0] tap_s3_reg;
	logic [3:0] tap_state_reg;
	// The first stage may be metastable, so only later stages are compared
	wire tap_stable = (tap_s3_reg == tap_s2_reg);

	// Status view only; nothing here steers logic
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			tap_s1_reg <= 4'h0;
			tap_s2_reg <= 4'h0;
			tap_s3_reg <= 4'h0;
			tap_state_reg <= 4'h0;
		end
		else
		begin
			tap_s1_reg <= link.state;
			tap_s2_reg <= tap_s1_reg;
			tap_s3_reg <= tap_s2_reg;
			if (tap_stable)
				tap_state_reg <= tap_s3_reg;
		end
	end

	assign tap_state_out = tap_state_reg;

	// Disable style shared by all outputs
	wire gated_style = s_style_pin | s_cfg_gated; // R02 R04
	wire stop_true = ~s_cfg_stop_level; // R03
	wire stop_comp = s_cfg_stop_level; // R03

	// Bank outputs: a disable or enable only takes effect while the source
	// sits at the true stop level, so no runt pulse leaves the pin
	// Each bank keeps its own registers so that one process drives each
	generate
		for (genvar b = 0; b < NUM_BANKS; b++)
		begin : g_bank
			logic bank_dis_reg;
			logic bank_true_reg;
			logic bank_comp_reg;
			logic bank_oe_n_reg;
			wire dis_req = bank_sync2_reg[b] | bit_sync2_reg[b] | ~s_power_down_n; // R13
			wire at_stop = (bank_src_in[b] == stop_true);
			wire dis_next = at_stop ? dis_req : bank_dis_reg; // R13

			// One bank's output stage
			always_ff @(posedge ref_clk_in)
			begin
				if (reset_in)
				begin
					bank_dis_reg <= 1'b1;
					bank_true_reg <= 1'b0;
					bank_comp_reg <= 1'b0;
					bank_oe_n_reg <= `OE_N_RST;
				end
				else
				begin
					bank_dis_reg <= dis_next;
					bank_true_reg <= dis_next ? stop_true : bank_src_in[b]; // R03
					bank_comp_reg <= dis_next ? stop_comp : ~bank_src_in[b]; // R03
					bank_oe_n_reg <= dis_next & ~gated_style; // R04
				end
			end

			assign bank_clk_out[b] = bank_true_reg;
			assign bank_clk_n_out[b] = bank_comp_reg;
			assign bank_oe_n_out[b] = bank_oe_n_reg;
		end
	endgenerate

	// Feedback output stops only on power-down
	logic fb_dis_reg;
	logic fb_true_reg;
	logic fb_comp_reg;
	logic fb_oe_n_reg;
	wire fb_at_stop = (feedback_src_in == stop_true);
	wire fb_dis_next = fb_at_stop ? ~s_power_down_n : fb_dis_reg;

	// Same glitch-free rule as the banks
	always_ff @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			fb_dis_reg <= 1'b1;
			fb_true_reg <= 1'b0;
			fb_comp_reg <= 1'b0;
			fb_oe_n_reg <= `OE_N_RST;
		end
		else
		begin
			fb_dis_reg <= fb_dis_next;
			fb_true_reg <= fb_dis_next ? stop_true : feedback_src_in; // R03
			fb_comp_reg <= fb_dis_next ? stop_comp : ~feedback_src_in; // R03
			fb_oe_n_reg <= fb_dis_next & ~gated_style; // R02 R04
		end
	end

	assign feedback_clk_out = fb_true_reg;
	assign feedback_clk_n_out = fb_comp_reg;
	assign feedback_oe_n_out = fb_oe_n_reg;
endmodule : clk_ctl_top
`default_nettype wire

//--- clk_ctl_asserts.sv
/*
 * Port-level assertions for the clock driver control block.
 * Assumes it is bound onto clk_ctl_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module clk_ctl_asserts #(parameter int NUM_BANKS = 5) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic trst_sel_n_in,
	input wire logic tms_strap_lo_in,
	input wire logic tdo_strap_hi_in,
	input wire logic tdo_oe_n_out,
	input wire logic pll_locked_in,
	input wire logic disable_style_pin_in,
	input wire logic cfg_gated_disable_in,
	input wire logic cfg_stop_level_in,
	input wire logic power_down_n_in,
	input wire logic [NUM_BANKS-1:0] bank_output_disable_n_in,
	input wire logic [NUM_BANKS-1:0] cfg_bank_disable_in,
	input wire logic [NUM_BANKS-1:0] bank_clk_out,
	input wire logic [NUM_BANKS-1:0] bank_clk_n_out,
	input wire logic [NUM_BANKS-1:0] bank_oe_n_out,
	input wire logic feedback_clk_out,
	input wire logic feedback_clk_n_out,
	input wire logic feedback_oe_n_out,
	input wire logic lock_out,
	input wire logic jtag_mode_out,
	input wire logic i2c_mode_out,
	input wire logic [1:0] target_id_out,
	input wire logic [3:0] tap_state_out
);
	logic gated_mode;
	logic [NUM_BANKS-1:0] bank_off;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	// Decoded conditions; sources must have passed the stop level within 8 cycles
	assign gated_mode = disable_style_pin_in | cfg_gated_disable_in;
	assign bank_off = bank_output_disable_n_in | cfg_bank_disable_in;
	sequence s_stop_gated;
		(!power_down_n_in && gated_mode && $stable(cfg_stop_level_in))[*8];
	endsequence
	sequence s_stop_hiz;
		(!power_down_n_in && !gated_mode)[*8];
	endsequence
	sequence s_banks_off;
		(power_down_n_in && !gated_mode && (&bank_off))[*8];
	endsequence
	chk_lock_follow: assert property ($stable(pll_locked_in)[*4] |-> lock_out == pll_locked_in)
		else $error("lock output does not follow pll lock");
	chk_stop_level: assert property (s_stop_gated |-> bank_clk_out == {NUM_BANKS{~cfg_stop_level_in}}
		&& bank_clk_n_out == {NUM_BANKS{cfg_stop_level_in}} && bank_oe_n_out == '0
		&& feedback_clk_out == ~cfg_stop_level_in && feedback_clk_n_out == cfg_stop_level_in)
		else $error("gated stop level wrong");
	chk_stop_hiz: assert property (s_stop_hiz |-> (&bank_oe_n_out) && feedback_oe_n_out)
		else $error("stopped outputs not released");
	chk_bank_off: assert property (s_banks_off |-> (&bank_oe_n_out) && !feedback_oe_n_out)
		else $error("disabled banks still driven");
	chk_bank_run: assert property ((power_down_n_in && bank_off == '0)[*8]
		|-> bank_oe_n_out == '0 && bank_clk_n_out == ~bank_clk_out)
		else $error("enabled banks not running");
	chk_mode_pair: assert property (jtag_mode_out != i2c_mode_out)
		else $error("mode outputs not complementary");
	chk_mode_follow: assert property ($stable(trst_sel_n_in)[*4] |-> jtag_mode_out == trst_sel_n_in)
		else $error("mode does not follow select pin");
	chk_tdo_release: assert property (!trst_sel_n_in |-> tdo_oe_n_out)
		else $error("serial output driven in two-wire mode");
	chk_tap_held: assert property ((!trst_sel_n_in)[*6] |-> tap_state_out == 4'h0)
		else $error("tap not held in reset");
	chk_id_hold: assert property (trst_sel_n_in[*6] |-> $stable(target_id_out))
		else $error("target id moved in test mode");
	chk_id_follow: assert property ((!trst_sel_n_in && $stable({tdo_strap_hi_in, tms_strap_lo_in}))[*4]
		|-> target_id_out == {tdo_strap_hi_in, tms_strap_lo_in})
		else $error("target id does not follow straps");
endmodule : clk_ctl_asserts
`default_nettype wire

//--- jtag_host.sv
/*
 * Test-port host model: drives test clock, mode select and serial data in.
 * Assumes the device updates its serial output on the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in,
	input wire logic tdo_oe_n_in
);
	logic seen_tdo;
	logic seen_oe_n;
	// Clock stands low between frames
	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	// One 12 ns test clock; inputs settle half a period before the rising edge
	task automatic tick(input logic tms, input logic tdi);
		tms_out = tms;
		tdi_out = tdi;
		#6 tck_out = 1'b1;
		seen_tdo = tdo_in;
		seen_oe_n = tdo_oe_n_in;
		#6 tck_out = 1'b0;
	endtask : tick
	// Data frame from idle or reset back to idle; bad flags a wrong enable
	task automatic frame(input logic [7:0] din, output logic [7:0] dout, output logic bad);
		tick(1'b0, 1'b0);
		tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b0);
		bad = seen_oe_n !== 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			tick(i == 7, din[i]);
			dout[i] = seen_tdo;
			bad |= seen_oe_n !== 1'b0;
		end
		tick(1'b1, 1'b0);
		bad |= seen_oe_n !== 1'b1;
		tick(1'b0, 1'b0);
	endtask : frame
endmodule : jtag_host
`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench for the clock driver control block.
 * Assumes design, interface, host model and checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int NB = 5;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic sel_n = 1'b0;
	logic strap_lo = 1'b0;
	logic strap_hi = 1'b0;
	logic pll_locked = 1'b0;
	logic style_pin = 1'b0;
	logic cfg59 = 1'b0;
	logic cfg58 = 1'b0;
	logic pd_n = 1'b1;
	logic [NB-1:0] oe_dis_n = '0;
	logic [NB-1:0] cfg_dis = '0;
	logic [NB-1:0] src = '0;
	logic fb_src = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe_n, fb, fbn, fb_oe_n, lock, jm, im, valid, bad;
	logic [NB-1:0] q, qn, q_oe_n;
	logic [1:0] tid;
	logic [3:0] tstate;
	logic [7:0] cword, w, d;
	int error_cnt = 0;
	int checks = 0;
	// Shared pin carries mode select in test mode, low strap otherwise
	wire logic tms_pin = sel_n ? tms : strap_lo;
	always #25 ref_clk_in = ~ref_clk_in;
	// Bank sources toggle so that stops always meet their level soon
	always @(negedge ref_clk_in)
	begin
		src <= ~src;
		fb_src <= ~fb_src;
	end
	clk_ctl_top #(.NUM_BANKS(NB), .DR_WIDTH(8)) dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.test_clock_in(tck), .trst_sel_n_in(sel_n), .tms_strap_lo_in(tms_pin), .tdi_in(tdi),
		.tdo_strap_hi_in(strap_hi), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
		.pll_locked_in(pll_locked), .disable_style_pin_in(style_pin),
		.cfg_gated_disable_in(cfg59), .cfg_stop_level_in(cfg58), .power_down_n_in(pd_n),
		.bank_output_disable_n_in(oe_dis_n), .cfg_bank_disable_in(cfg_dis), .bank_src_in(src),
		.feedback_src_in(fb_src), .bank_clk_out(q), .bank_clk_n_out(qn), .bank_oe_n_out(q_oe_n),
		.feedback_clk_out(fb), .feedback_clk_n_out(fbn), .feedback_oe_n_out(fb_oe_n),
		.lock_out(lock), .jtag_mode_out(jm), .i2c_mode_out(im), .target_id_out(tid),
		.tap_state_out(tstate), .cfg_word_out(cword), .cfg_word_valid_out(valid));
	jtag_host host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
		.tdo_oe_n_in(tdo_oe_n));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : cyc
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// A stopped output is driven only in the gated style
	function automatic logic stop_oe_n(input logic pin, input logic bit59);
		return ~(pin | bit59);
	endfunction : stop_oe_n
	// One frame; the word differs from the core's so a fresh pulse must come
	task automatic run_frame(input logic [7:0] prev);
		int n;
		w = cword ^ 8'($urandom_range(255, 1));
		host.frame(w, d, bad);
		chk("tdo_data", prev, d);
		chk("tdo_enable", 8'h00, 8'(bad));
		for (n = 0; n < 20 && valid !== 1'b1; n++)
			cyc(1);
		if (n == 20)
		begin
			error_cnt++;
			stop_test();
		end
		chk("cfg_word", w, cword);
		cyc(4);
		chk("tap_idle", 8'(clk_ctl_pkg::TAP_IDLE), 8'(tstate));
	endtask : run_frame
	initial
	begin
		void'($urandom(32'h0000_4d1a));
		cyc(8);
		reset_in <= 1'b0;
		// Lock indication through the synchroniser
		repeat (8)
		begin
			pll_locked <= 1'($urandom);
			cyc(5);
			chk("lock", 8'(pll_locked), 8'(lock));
		end
		$display("test lock done");
		// Every disable style and stop level while powered down
		pd_n <= 1'b0;
		for (int m = 0; m < 8; m++)
		begin
			{style_pin, cfg59, cfg58} <= 3'(m);
			cyc(12);
			chk("stop_q", 8'({NB{~cfg58}}), 8'(q));
			chk("stop_qn", 8'({NB{cfg58}}), 8'(qn));
			chk("stop_fb", 8'({~cfg58, cfg58}), 8'({fb, fbn}));
			chk("stop_oe", 8'({(NB+1){stop_oe_n(style_pin, cfg59)}}), 8'({q_oe_n, fb_oe_n}));
		end
		$display("test stop styles done");
		// Bank enables: corners first, then random pin and bit mixes
		pd_n <= 1'b1;
		{style_pin, cfg59} <= 2'b00;
		for (int k = 0; k < 8; k++)
		begin
			oe_dis_n <= (k == 0) ? '0 : (k == 1) ? '1 : NB'($urandom);
			cfg_dis <= (k < 2) ? '0 : NB'($urandom);
			cyc(12);
			chk("bank_oe", 8'(oe_dis_n | cfg_dis), 8'(q_oe_n));
			chk("fb_oe", 8'h00, 8'(fb_oe_n));
		end
		$display("test bank enables done");
		// Two-wire mode: straps set the id, tap held, serial output released
		for (int k = 0; k < 4; k++)
		begin
			{strap_hi, strap_lo} <= 2'(k);
			cyc(6);
			chk("target_id", 8'(k), 8'(tid));
			chk("mode", 8'h01, 8'({jm, im}));
			chk("tap_reset", 8'h00, 8'(tstate));
			chk("tdo_off", 8'h01, 8'(tdo_oe_n));
		end
		sel_n <= 1'b1;
		strap_hi <= 1'b0;
		cyc(6);
		chk("id_hold", 8'h03, 8'(tid));
		chk("mode", 8'h02, 8'({jm, im}));
		$display("test select done");
		// Frames read back the previous word
		run_frame(8'h00);
		run_frame(w);
		run_frame(w);
		// Select pin dropped in mid-shift releases the output with no clock
		host.tick(1'b0, 1'b0);
		host.tick(1'b1, 1'b0);
		host.tick(1'b0, 1'b0);
		host.tick(1'b0, 1'b0);
		host.tick(1'b0, 1'b0);
		chk("oe_shift", 8'h00, 8'(tdo_oe_n));
		sel_n <= 1'b0;
		#1;
		chk("oe_async", 8'h01, 8'(tdo_oe_n));
		cyc(8);
		chk("tap_reset", 8'h00, 8'(tstate));
		sel_n <= 1'b1;
		cyc(6);
		run_frame(8'h00);
		$display("test frames done");
		stop_test();
	end
endmodule : testbench
bind clk_ctl_top clk_ctl_asserts #(.NUM_BANKS(NUM_BANKS)) checks_i (.ref_clk_in, .reset_in,
	.trst_sel_n_in, .tms_strap_lo_in, .tdo_strap_hi_in, .tdo_oe_n_out, .pll_locked_in,
	.disable_style_pin_in, .cfg_gated_disable_in, .cfg_stop_level_in, .power_down_n_in,
	.bank_output_disable_n_in, .cfg_bank_disable_in, .bank_clk_out, .bank_clk_n_out,
	.bank_oe_n_out, .feedback_clk_out, .feedback_clk_n_out, .feedback_oe_n_out, .lock_out,
	.jtag_mode_out, .i2c_mode_out, .target_id_out, .tap_state_out);
`default_nettype wire
